/* File: common/ea_pkg.sv */
/*
 * constants, types and helpers for the effective address generator.
 * assumes a 24-bit address space and a 100 MHz cpu clock.
 */
package ea_pkg;

  // ----------------------------------------------------------------
  // widths and constants
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int NUM_REGS = 8;
  localparam logic [15:0] ABS8_FILL = 16'hFFFF;
  localparam logic [15:0] MEMIND_FILL = 16'h0000;
  localparam logic [7:0] FIELD24_TOP = 8'h00;
  localparam logic [3:0] M1_TOP = 4'h0;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [7:0] WONLY_READ = 8'hFF;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    am_direct, am_indirect, am_disp, am_postinc, am_predec,
    am_abs, am_imm, am_pcrel, am_memind
  } amode_t;
  typedef enum logic [1:0] {sz_byte, sz_word, sz_long} size_t;
  typedef enum logic [1:0] {len_8, len_16, len_24} alen_t;
  typedef enum logic [2:0] {
    cls_alu, cls_xfer, cls_bit, cls_jump, cls_trap
  } opclass_t;
  typedef enum logic [2:0] {
    bit_set_op, bit_clear_op, bit_invert_op, bit_store_op,
    bit_store_inverted_op, bit_test_op
  } bitop_t;
  typedef enum logic [2:0] {
    st_idle = 3'b000, st_read = 3'b001, st_write = 3'b011,
    st_done = 3'b010, st_ind = 3'b110
  } state_t;

  // ----------------------------------------------------------------
  // address finishing: even forcing and 1-Mbyte truncation
  // ----------------------------------------------------------------
  function automatic logic [23:0] finish_addr(input logic [23:0] a,
      input logic even, input logic m1);
    logic [23:0] r;
    r = a;
    if (even) r[0] = 1'b0;
    if (m1) r[23:20] = M1_TOP;
    return r;
  endfunction : finish_addr

endpackage : ea_pkg

/* File: common/ea_if.sv */
/*
 * carries one address calculation request and its result.
 * assumes the calculator is purely combinational.
 */
`timescale 1ns/100ps
interface ea_if;
  import ea_pkg::*;
  amode_t mode;
  size_t size;
  alen_t alen;
  logic disp_wide;
  logic [23:0] disp;
  logic [23:0] abs_field;
  logic [23:0] pc_next;
  logic m1;
  logic [31:0] base;
  logic [31:0] direct_reg;
  logic [3:0] rsel;
  logic [31:0] imm;
  logic [23:0] ea;
  logic [31:0] wb_val;
  logic wb_en;
  logic [31:0] operand;
  modport calc (input mode, size, alen, disp_wide, disp, abs_field,
    pc_next, m1, base, direct_reg, rsel, imm,
    output ea, wb_val, wb_en, operand);
  modport user (output mode, size, alen, disp_wide, disp, abs_field,
    pc_next, m1, base, direct_reg, rsel, imm,
    input ea, wb_val, wb_en, operand);
endinterface : ea_if

/* File: hdl/ea_calc.sv */
/*
 * combinational effective address and operand calculation.
 * assumes the caller supplies the addressed register contents.
 */
`timescale 1ns/100ps
module ea_calc
  import ea_pkg::*;
(
  ea_if.calc c
);
  logic [31:0] dext;
  logic [31:0] step;
  logic [31:0] sum;
  logic [23:0] raw;
  logic [23:0] pdisp;

  // displacement extension and step size
  always_comb begin
    if (c.disp_wide) dext = {FIELD24_TOP, c.disp};
    else dext = {{16{c.disp[15]}}, c.disp[15:0]};
    unique case (c.size)
      sz_byte: step = STEP_BYTE;
      sz_word: step = STEP_WORD;
      default: step = STEP_LONG;
    endcase
    if (c.alen == len_8) pdisp = {{16{c.disp[7]}}, c.disp[7:0]};
    else pdisp = {{8{c.disp[15]}}, c.disp[15:0]};
  end

  // raw address per mode, plus write-back
  always_comb begin
    raw = '0;
    sum = '0;
    c.wb_en = 1'b0;
    c.wb_val = c.base;
    unique case (c.mode)
      am_indirect: raw = c.base[23:0];
      am_disp: begin
        sum = c.base + dext;
        raw = sum[23:0];
      end
      am_postinc: begin
        raw = c.base[23:0];
        c.wb_val = c.base + step;
        c.wb_en = 1'b1;
      end
      am_predec: begin
        sum = c.base - step;
        raw = sum[23:0];
        c.wb_val = sum;
        c.wb_en = 1'b1;
      end
      am_abs: begin
        unique case (c.alen)
          len_8: raw = {ABS8_FILL, c.abs_field[7:0]};
          len_16: raw = {{8{c.abs_field[15]}}, c.abs_field[15:0]};
          default: raw = c.abs_field;
        endcase
      end
      am_pcrel: raw = c.pc_next + pdisp;
      am_memind: raw = {MEMIND_FILL, c.abs_field[7:0]};
      default: raw = '0;
    endcase
    c.ea = finish_addr(raw, c.size != sz_byte || c.mode == am_pcrel
      || c.mode == am_memind, c.m1);
  end

  // operand for register direct and immediate
  always_comb begin
    c.operand = '0;
    if (c.mode == am_imm) begin
      unique case (c.size)
        sz_byte: c.operand = {24'h000000, c.imm[7:0]};
        sz_word: c.operand = {16'h0000, c.imm[15:0]};
        default: c.operand = c.imm;
      endcase
    end else if (c.mode == am_direct) begin
      unique case (c.size)
        sz_byte: c.operand = {24'h000000, c.rsel[3] ?
          c.direct_reg[7:0] : c.direct_reg[15:8]};
        sz_word: c.operand = {16'h0000, c.rsel[3] ?
          c.direct_reg[31:16] : c.direct_reg[15:0]};
        default: c.operand = c.direct_reg;
      endcase
    end
  end
endmodule : ea_calc

/* File: hdl/bit_modify.sv */
/*
 * single-bit change of one byte for the bit instructions.
 * assumes the bit number is already resolved to three bits.
 */
`timescale 1ns/100ps
module bit_modify
  import ea_pkg::*;
(
  input wire logic [7:0] byte_in,
  input wire logic [2:0] bit_num,
  input wire bitop_t op,
  input wire logic carry,
  output logic [7:0] byte_out,
  output logic test_bit
);
  // change only the selected bit
  always_comb begin
    byte_out = byte_in;
    test_bit = byte_in[bit_num];
    unique case (op)
      bit_set_op: byte_out[bit_num] = 1'b1;
      bit_clear_op: byte_out[bit_num] = 1'b0;
      bit_invert_op: byte_out[bit_num] = ~byte_in[bit_num];
      bit_store_op: byte_out[bit_num] = carry;
      bit_store_inverted_op: byte_out[bit_num] = ~carry;
      default: byte_out = byte_in;
    endcase
  end
endmodule : bit_modify

/* File: hdl/effective_address_generator.sv */
/*
 * effective address generator with its extended register file,
 * operand fetch and bit read-modify-write sequencing.
 * assumes the decoder holds its fields stable while start is high
 * and raises start only while busy is low; the memory bus answers
 * a held request with a one-cycle ack.
 */
`timescale 1ns/100ps
module effective_address_generator
  import ea_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire opclass_t op_class,
  input wire amode_t mode,
  input wire size_t size,
  input wire alen_t alen,
  input wire logic disp_wide,
  input wire logic [23:0] disp,
  input wire logic [23:0] abs_field,
  input wire logic [31:0] imm,
  input wire logic [23:0] pc_next,
  input wire logic [3:0] rsel,
  input wire bitop_t bit_op,
  input wire logic bit_from_reg,
  input wire logic [3:0] bit_rsel,
  input wire logic carry,
  input wire logic mode_1m,
  input wire logic xfer_write,
  input wire logic [31:0] xfer_wdata,
  input wire logic rf_we,
  input wire logic [2:0] rf_wsel,
  input wire logic [31:0] rf_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_wonly,
  output logic busy,
  output logic done,
  output logic mode_error,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output size_t mem_size,
  output logic [31:0] mem_wdata,
  output logic [23:0] eff_addr,
  output logic [31:0] operand,
  output logic [23:0] branch_target,
  output logic branch_valid,
  output logic test_bit,
  output logic [1:0] trap_vector
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [31:0] regs [NUM_REGS];
  state_t state;
  opclass_t cls_q;
  bitop_t bop_q;
  logic [2:0] bitn_q;
  logic carry_q;
  logic m1_q;
  logic legal;
  logic mem_mode;
  logic [2:0] bitn;
  logic [7:0] bit_byte;
  logic [7:0] rd_byte;
  logic [7:0] mod_byte;
  logic mod_test;
  logic [31:0] next_reg;
  logic [7:0] bitsrc;

  ea_if calc_bus ();

  // ----------------------------------------------------------------
  // address calculation
  // ----------------------------------------------------------------
  // bit ops work on a byte, branch targets are forced even like longs
  assign calc_bus.mode = mode;
  assign calc_bus.size = (op_class == cls_bit) ? sz_byte
    : (op_class == cls_jump) ? sz_long : size;
  assign calc_bus.alen = alen;
  assign calc_bus.disp_wide = disp_wide;
  assign calc_bus.disp = disp;
  assign calc_bus.abs_field = abs_field;
  assign calc_bus.pc_next = pc_next;
  assign calc_bus.m1 = mode_1m;
  assign calc_bus.base = regs[rsel[2:0]];
  assign calc_bus.direct_reg = regs[rsel[2:0]];
  assign calc_bus.rsel = rsel;
  assign calc_bus.imm = imm;

  ea_calc u_calc (
    .c(calc_bus.calc)
  );

  // ----------------------------------------------------------------
  // legality of the mode for the instruction class
  // ----------------------------------------------------------------
  always_comb begin
    legal = 1'b0;
    unique case (op_class)
      cls_alu: legal = mode == am_direct || mode == am_imm;
      cls_xfer: legal = mode != am_pcrel && mode != am_memind;
      cls_bit: legal = (mode == am_direct || mode == am_indirect
        || (mode == am_abs && alen == len_8))
        && (!bit_from_reg || bit_op == bit_set_op
        || bit_op == bit_clear_op || bit_op == bit_invert_op
        || bit_op == bit_test_op);
      cls_jump: legal = mode == am_pcrel || mode == am_memind
        || mode == am_indirect || mode == am_abs;
      default: legal = mode == am_imm; // trap carries an immediate
    endcase
    mem_mode = mode != am_direct && mode != am_imm && mode != am_pcrel
      && !(op_class == cls_jump && mode != am_memind);
  end

  // bit number from register byte or 3-bit immediate
  always_comb begin
    bitsrc = bit_rsel[3] ? regs[bit_rsel[2:0]][7:0]
      : regs[bit_rsel[2:0]][15:8];
    bitn = bit_from_reg ? bitsrc[2:0] : imm[2:0];
  end

  // ----------------------------------------------------------------
  // bit modify path
  // ----------------------------------------------------------------
  // write-only targets read back as all ones
  assign rd_byte = mem_wonly ? WONLY_READ : mem_rdata[7:0];
  assign bit_byte = (state == st_read) ? rd_byte : calc_bus.operand[7:0];

  bit_modify u_bit (
    .byte_in(bit_byte),
    .bit_num(state == st_read ? bitn_q : bitn),
    .op(state == st_read ? bop_q : bit_op),
    .carry(state == st_read ? carry_q : carry),
    .byte_out(mod_byte),
    .test_bit(mod_test)
  );

  // merged register value for a register-direct bit op
  always_comb begin
    next_reg = regs[rsel[2:0]];
    if (rsel[3]) next_reg[7:0] = mod_byte;
    else next_reg[15:8] = mod_byte;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (start && legal && mem_mode) state <= st_read;
          else if (start) state <= st_done;
        end
        st_read: begin
          if (mem_ack && cls_q == cls_jump) state <= st_ind;
          else if (mem_ack && cls_q == cls_bit && bop_q != bit_test_op)
            state <= st_write;
          else if (mem_ack) state <= st_done;
        end
        st_write: if (mem_ack) state <= st_done;
        st_ind: state <= st_done;
        st_done: state <= st_idle;
      endcase
    end
  end

  // latched instruction context
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cls_q <= cls_alu;
      bop_q <= bit_test_op;
      bitn_q <= 3'h0;
      carry_q <= 1'b0;
      m1_q <= 1'b0;
    end else if (state == st_idle && start) begin
      cls_q <= op_class;
      bop_q <= bit_op;
      bitn_q <= bitn;
      carry_q <= carry;
      m1_q <= mode_1m;
    end
  end

  // register file: address write-back beats decoder writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_REGS; i++) regs[i] <= 32'h0000_0000;
    end else if (state == st_idle && start && legal
        && calc_bus.wb_en) begin
      regs[rsel[2:0]] <= calc_bus.wb_val;
    end else if (state == st_idle && start && legal
        && op_class == cls_bit && mode == am_direct
        && bit_op != bit_test_op) begin
      regs[rsel[2:0]] <= next_reg;
    end else if (rf_we) begin
      regs[rf_wsel] <= rf_wdata;
    end
  end

  // memory bus request, address, size and data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 24'h000000;
      mem_size <= sz_byte;
      mem_wdata <= 32'h0000_0000;
    end else if (state == st_idle && start && legal && mem_mode) begin
      mem_req <= 1'b1;
      mem_we <= op_class == cls_xfer && xfer_write;
      mem_addr <= calc_bus.ea;
      mem_size <= (op_class == cls_jump) ? sz_long
        : calc_bus.size;
      mem_wdata <= xfer_wdata;
    end else if (state == st_read && mem_ack && cls_q == cls_bit
        && bop_q != bit_test_op) begin
      mem_we <= 1'b1;
      mem_wdata <= {24'h000000, mod_byte};
    end else if (mem_ack) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
    end
  end

  // results toward the decoder
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eff_addr <= 24'h000000;
      operand <= 32'h0000_0000;
      branch_target <= 24'h000000;
      branch_valid <= 1'b0;
      test_bit <= 1'b0;
      trap_vector <= 2'h0;
      mode_error <= 1'b0;
    end else begin
      branch_valid <= 1'b0;
      mode_error <= 1'b0;
      if (state == st_idle && start) begin
        mode_error <= !legal;
        eff_addr <= calc_bus.ea;
        operand <= calc_bus.operand;
        if (op_class == cls_trap) trap_vector <= imm[1:0];
        if (op_class == cls_bit && mode == am_direct) test_bit <= mod_test;
        if (legal && op_class == cls_jump && mode != am_memind) begin
          branch_target <= calc_bus.ea;
          branch_valid <= 1'b1;
        end
      end else if (state == st_read && mem_ack) begin
        operand <= mem_rdata;
        if (cls_q == cls_bit) test_bit <= mod_test;
        if (cls_q == cls_jump)
          branch_target <= finish_addr(mem_rdata[23:0], 1'b1, m1_q);
      end else if (state == st_ind) begin
        branch_valid <= 1'b1;
      end
    end
  end

  // busy level and done pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= (state == st_idle) ? start : (state != st_done);
      done <= (state == st_done);
    end
  end

endmodule : effective_address_generator

/* File: testbench/ea_assertions.sv */
/*
 * concurrent checks on the ports of the address generator top.
 * assumes the bind below and one clock with an active low reset.
 */
`timescale 1ns/100ps
module ea_assertions
  import ea_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic busy,
  input wire opclass_t op_class,
  input wire amode_t mode,
  input wire size_t size,
  input wire alen_t alen,
  input wire logic [23:0] abs_field,
  input wire logic mode_1m,
  input wire logic mem_wonly,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire size_t mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic done,
  input wire logic mode_error
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic take;
  logic m1_q;
  logic [23:0] abs_q;
  logic [7:0] rd_q;
  assign take = start && !busy;
  // fields latched at the taking edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {m1_q, abs_q} <= '0;
    end else if (take) begin
      {m1_q, abs_q} <= {mode_1m, abs_field};
    end
  end
  // byte returned to the read half of a bit change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= 8'h00;
    end else if (mem_ack && !mem_we) begin
      rd_q <= mem_wonly ? WONLY_READ : mem_rdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_abs8;
    take && op_class == cls_xfer && mode == am_abs && alen == len_8 &&
      size == sz_byte && !mode_1m |=> mem_req &&
      mem_addr == {ABS8_FILL, abs_q[7:0]};
  endproperty
  a_abs8: assert property (p_abs8)
    else $error("short absolute address not filled with ones");
  property p_abs16;
    take && op_class == cls_xfer && mode == am_abs && alen == len_16 &&
      size == sz_byte && !mode_1m |=> mem_req &&
      mem_addr == {{8{abs_q[15]}}, abs_q[15:0]};
  endproperty
  a_abs16: assert property (p_abs16)
    else $error("16-bit absolute address not sign extended");
  property p_m1;
    mem_req && m1_q |-> mem_addr[23:20] == M1_TOP;
  endproperty
  a_m1: assert property (p_m1)
    else $error("top address bits kept in 1-Mbyte mode");
  property p_even;
    mem_req && mem_size != sz_byte |-> !mem_addr[0];
  endproperty
  a_even: assert property (p_even)
    else $error("odd address on wide access");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_rmw;
    mem_req && mem_we && $past(mem_req) && !$past(mem_we) |->
      mem_addr == $past(mem_addr) && mem_size == sz_byte &&
      $countones(mem_wdata[7:0] ^ rd_q) <= 1;
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("bit write back differs from read byte");
  property p_memind;
    take && op_class == cls_jump && mode == am_memind |=> mem_req &&
      mem_size == sz_long && mem_addr == {MEMIND_FILL, abs_q[7:1], 1'b0};
  endproperty
  a_memind: assert property (p_memind)
    else $error("memory indirect pointer wrong");
  property p_illegal;
    take && op_class == cls_alu && mode != am_direct && mode != am_imm
      |=> mode_error && !mem_req ##1 done && !mem_req;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal alu mode not refused");
  property p_done;
    take |=> busy ##[1:40] done;
  endproperty
  a_done: assert property (p_done)
    else $error("request not completed in time");
endmodule : ea_assertions

bind effective_address_generator ea_assertions ea_assertions_i (
  .clk(clk), .rstn(rstn), .start(start), .busy(busy),
  .op_class(op_class), .mode(mode), .size(size), .alen(alen),
  .abs_field(abs_field), .mode_1m(mode_1m), .mem_wonly(mem_wonly),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
  .mem_wdata(mem_wdata), .done(done), .mode_error(mode_error)
);

/* File: testbench/mem_model.sv */
/*
 * memory bus partner: acks each held request after a chosen wait.
 * assumes one request at a time, completed by a one-cycle ack.
 */
`timescale 1ns/100ps
module mem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] dly,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic [23:0] wr_addr,
  output logic [31:0] wr_data
);
  logic [1:0] cnt;
  // ack after dly waits; read data is only valid with the ack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {mem_ack, cnt, mem_rdata, wr_addr, wr_data} <= '0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && cnt >= dly) begin
      mem_ack <= 1'b1;
      mem_rdata <= {8'hC3, ~mem_addr};
      if (mem_we) begin
        wr_addr <= mem_addr;
        wr_data <= mem_wdata;
      end
    end else begin
      cnt <= mem_req ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mem_model

/* File: testbench/test_effective_address_generator.sv */
/*
 * self-checking bench for the effective address generator.
 * assumes the memory model answers every held request.
 */
`timescale 1ns/100ps
module test_effective_address_generator
  import ea_pkg::*;
;
  logic clk, rstn, start, disp_wide, bit_from_reg, carry, mode_1m;
  logic xfer_write, rf_we, mem_ack, mem_wonly, busy, done, mode_error;
  logic mem_req, mem_we, branch_valid, test_bit, got, saw_err, saw_bv, w;
  opclass_t op_class;
  amode_t mode;
  size_t size, mem_size;
  alen_t alen;
  bitop_t bit_op;
  logic [23:0] disp, abs_field, pc_next, mem_addr, eff_addr, a, e, d;
  logic [23:0] branch_target, wr_addr, a_seen;
  logic [31:0] imm, xfer_wdata, rf_wdata, mem_rdata, mem_wdata, operand;
  logic [31:0] wr_data, r, x;
  logic [3:0] rsel, bit_rsel;
  logic [2:0] rf_wsel, k;
  logic [1:0] trap_vector, dly;
  logic [7:0] v;
  int err_total, compares, n, st;
  opclass_t ic[5] = '{cls_alu, cls_xfer, cls_xfer, cls_trap, cls_bit};
  amode_t im[5] = '{am_indirect, am_pcrel, am_memind, am_direct, am_disp};

  effective_address_generator effective_address_generator_i (
    .clk(clk), .rstn(rstn), .start(start), .op_class(op_class),
    .mode(mode), .size(size), .alen(alen), .disp_wide(disp_wide),
    .disp(disp), .abs_field(abs_field), .imm(imm), .pc_next(pc_next),
    .rsel(rsel), .bit_op(bit_op), .bit_from_reg(bit_from_reg),
    .bit_rsel(bit_rsel), .carry(carry), .mode_1m(mode_1m),
    .xfer_write(xfer_write), .xfer_wdata(xfer_wdata), .rf_we(rf_we),
    .rf_wsel(rf_wsel), .rf_wdata(rf_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_wonly(mem_wonly), .busy(busy),
    .done(done), .mode_error(mode_error), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .eff_addr(eff_addr), .operand(operand),
    .branch_target(branch_target), .branch_valid(branch_valid),
    .test_bit(test_bit), .trap_vector(trap_vector));
  mem_model mem_model_i (.clk(clk), .rstn(rstn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .dly(dly), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .wr_addr(wr_addr), .wr_data(wr_data));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [23:0] ef(logic [23:0] ad, logic ev);
    ef = ad & {mode_1m ? 4'h0 : 4'hF, 19'h7FFFF, !ev};
  endfunction : ef
  task automatic chk(string nm, logic [31:0] s, logic [31:0] ex);
    compares++;
    if (s !== ex) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // issue one request at a clock edge and follow it to done
  task automatic go(opclass_t cl, amode_t m, size_t s);
    op_class <= cl;
    mode <= m;
    size <= s;
    dly <= 2'($urandom % 3);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    {got, saw_err, saw_bv} = 3'b000;
    for (int i = 0; i < 60; i++) begin
      #1;
      if (mem_req === 1'b1 && !got) begin
        got = 1'b1;
        a_seen = mem_addr;
      end
      saw_err |= mode_error;
      saw_bv |= branch_valid;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    chk("done", done, 1);
    @(posedge clk);
  endtask : go
  task automatic wr(logic [2:0] sel, logic [31:0] val);
    rf_we <= 1'b1;
    rf_wsel <= sel;
    rf_wdata <= val;
    @(posedge clk);
    rf_we <= 1'b0;
  endtask : wr

  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn, start, disp_wide, bit_from_reg, carry, mode_1m} = '0;
    {xfer_write, rf_we, mem_wonly, dly, rsel, bit_rsel, rf_wsel} = '0;
    {disp, abs_field, pc_next, imm, xfer_wdata, rf_wdata} = '0;
    {op_class, mode, size, alen, bit_op} = '0;
    void'($urandom(32'h69EF));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("idle", {busy, done, mem_req, mem_size}, 0);
    @(posedge clk);
    for (n = 0; n < 16; n++) begin
      a = (n == 1) ? 24'h008001 : 24'($urandom);
      x = $urandom;
      abs_field <= a;
      alen <= alen_t'(n % 3);
      mode_1m <= n[2];
      xfer_write <= n[0];
      xfer_wdata <= x;
      go(cls_xfer, am_abs, sz_byte);
      e = n % 3 == 0 ? {16'hFFFF, a[7:0]} :
        n % 3 == 1 ? {{8{a[15]}}, a[15:0]} : a;
      chk("abs_addr", a_seen, ef(e, 0));
      chk("eff_addr", eff_addr, ef(e, 0));
      if (n[0]) chk("xfer_data", wr_data[7:0], x[7:0]);
    end
    r = 32'h0012_3457;
    mode_1m <= 1'b0;
    rsel <= 4'h2;
    wr(3'd2, r);
    for (n = 0; n < 3; n++) begin
      st = 1 << n;
      go(cls_xfer, am_postinc, size_t'(n));
      chk("postinc", a_seen, ef(r[23:0], n != 0));
      r = r + st;
      go(cls_alu, am_direct, sz_long);
      chk("inc_reg", operand, r);
      go(cls_xfer, am_predec, size_t'(n));
      r = r - st;
      chk("predec", a_seen, ef(r[23:0], n != 0));
    end
    for (n = 0; n < 4; n++) begin
      rsel <= {n[0], 3'd2};
      go(cls_alu, am_direct, size_t'(n[1]));
      e = n[1] ? (n[0] ? r[31:16] : r[15:0]) : (n[0] ? r[7:0] : r[15:8]);
      chk("direct", operand & (n[1] ? 32'hFFFF : 32'hFF), e);
    end
    x = $urandom;
    rsel <= 4'h3;
    wr(3'd3, x);
    go(cls_xfer, am_indirect, sz_byte);
    chk("indirect", a_seen, x[23:0]);
    for (n = 0; n < 4; n++) begin
      d = {8'($urandom), n[1], 15'($urandom)};
      disp <= d;
      disp_wide <= n[0];
      go(cls_xfer, am_disp, sz_byte);
      e = x[23:0] + (n[0] ? d : {{8{d[15]}}, d[15:0]});
      chk("disp", a_seen, e);
    end
    for (n = 0; n < 12; n++) begin
      a = 24'($urandom);
      k = 3'($urandom);
      w = n > 5;
      abs_field <= a;
      alen <= len_8;
      bit_op <= bitop_t'(n % 6);
      imm <= {29'h0, k};
      carry <= n[1];
      mem_wonly <= w;
      go(cls_bit, am_abs, sz_byte);
      v = w ? 8'hFF : ~a[7:0];
      chk("bit_old", test_bit, v[k]);
      case (n % 6)
        0: v[k] = 1'b1;
        1: v[k] = 1'b0;
        2: v[k] = ~v[k];
        3: v[k] = n[1];
        default: v[k] = ~n[1];
      endcase
      if (n % 6 != 5) begin
        chk("rmw_addr", wr_addr, {16'hFFFF, a[7:0]});
        chk("rmw_data", wr_data[7:0], v);
      end
    end
    bit_op <= bit_invert_op;
    rsel <= 4'hA;
    go(cls_bit, am_direct, sz_byte);
    chk("bit_reg_old", test_bit, r[k]);
    r[k] = ~r[k];
    go(cls_alu, am_direct, sz_long);
    chk("bit_reg", operand, r);
    for (n = 0; n < 6; n++) begin
      a = 24'($urandom);
      d = 24'($urandom);
      pc_next <= a;
      disp <= d;
      alen <= alen_t'(n % 2);
      mode_1m <= n[2];
      go(cls_jump, am_pcrel, sz_byte);
      e = a + (n % 2 ? {{8{d[15]}}, d[15:0]} : {{16{d[7]}}, d[7:0]});
      chk("pcrel", branch_target, ef(e, 1));
      chk("bvalid", saw_bv, 1);
      abs_field <= d;
      go(cls_jump, am_memind, sz_long);
      chk("mi_ptr", a_seen, {16'h0000, d[7:1], 1'b0});
      chk("mi_tgt", branch_target, ef(~a_seen, 1));
      chk("mi_valid", saw_bv, 1);
    end
    rsel <= 4'h3;
    go(cls_jump, am_indirect, sz_byte);
    e = ef(x[23:0], 1);
    chk("jind", {got, saw_bv, branch_target}, {2'b01, e});
    x = $urandom;
    imm <= x;
    go(cls_trap, am_imm, sz_byte);
    chk("trap", trap_vector, x[1:0]);
    go(cls_alu, am_imm, sz_long);
    chk("imm", operand, x);
    for (n = 0; n < 5; n++) begin
      go(ic[n], im[n], sz_byte);
      chk("illegal", {saw_err, got}, 2'b10);
    end
    final_report();
  end
endmodule : test_effective_address_generator
